// file: verilog/dcs_pkg.sv
/*
 * Shared constants of the two-channel converter sequencer: timing, decimation
 * filter sizes, result word layout and state codes.
 * Assumes a 100 MHz reference clock and a host that clocks 24-bit frames.
 */
package dcs_pkg;

	// Reference clock and modulator rate
	localparam int unsigned CLK_HZ        = 100_000_000;  // Reference clock, Hz
	localparam int unsigned SAMPLE_HZ     = 15_360;       // Modulator sample rate, Hz
	localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ; // Longest period, rounded down

	// Sinc filter shape
	localparam int unsigned SINC_ORDER    = 4;            // Fourth-order sinc
	localparam int unsigned DECIM         = 256;          // Oversampling ratio
	localparam int unsigned CONV_SAMPLES  = SINC_ORDER * DECIM; // Samples per conversion
	localparam int unsigned ACC_W         = 33;           // 1 + 4*log2(256)
	localparam int unsigned SCNT_W        = 10;           // Sample counter width
	localparam logic [SCNT_W-1:0] LAST_SAMPLE = 10'h3ff;  // Final sample of a conversion
	localparam logic [7:0]  DECIM_LAST    = 8'hff;        // Last sample of a window

	// Result word layout, sent MSB first
	localparam int unsigned RES_W         = 20;           // Result code width
	localparam int unsigned WORD_W        = 24;           // Serial word width
	localparam int unsigned BIT_EOC       = 23;           // Low when result is ready
	localparam int unsigned BIT_CH        = 22;           // Channel flag
	localparam int unsigned BIT_SIGN      = 21;           // High for non-negative input
	localparam int unsigned BIT_EXR       = 20;           // Extended range flag
	localparam logic [RES_W-1:0] FULL_CODE = 20'hfffff;   // All-ones code
	localparam logic [RES_W-1:0] ZERO_CODE = 20'h00000;   // All-zeros code
	localparam logic [4:0]  LAST_BIT      = 5'h17;        // Index of the 24th bit

	// Buffering and start-up
	localparam int unsigned FIFO_DEPTH    = 8;            // Result words buffered
	localparam logic [1:0]  STRAP_WAIT    = 2'h3;         // Cycles before the strap sample

	// Sequencer states
	typedef enum logic [1:0] {
		ST_STRAP = 2'b00,  // Waiting to sample the clock strap
		ST_CONV  = 2'b01,  // Converting the selected input
		ST_SLEEP = 2'b10   // Result done, waiting for link activity
	} dcs_state_e;

endpackage

// file: verilog/dcs_fifo_if.sv
/*
 * Carrier between the sequencer and its result buffer: valid/ready on the
 * fill side and on the drain side.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/10ps
interface dcs_fifo_if #(
	parameter int unsigned W = 24
);
	logic         in_valid;   // Fill side offers a word
	logic         in_ready;   // Buffer has room
	logic [W-1:0] in_data;    // Word offered
	logic         out_valid;  // Buffer holds a word
	logic         out_ready;  // Drain side takes it
	logic [W-1:0] out_data;   // Oldest word

	modport buf_side (input in_valid, input in_data, input out_ready,
	                  output in_ready, output out_valid, output out_data);
	modport user_side (output in_valid, output in_data, output out_ready,
	                   input in_ready, input out_valid, input out_data);
endinterface

// file: verilog/dcs_fifo.sv
/*
 * Result buffer: synchronous FIFO with parameter width and depth.
 * Assumes a single clock; depth is a power of two.
 */
`timescale 1ns/10ps
module dcs_fifo
	import dcs_pkg::*;
#(
	parameter int unsigned W = 24,
	parameter int unsigned D = 8
) (
	input wire logic     clk,
	input wire logic     rstn,
	dcs_fifo_if.buf_side f
);
	localparam int unsigned AW = $clog2(D);

	logic [W-1:0]  mem [D];     // Word storage
	logic [AW-1:0] wr_ptr;      // Next slot written
	logic [AW-1:0] rd_ptr;      // Oldest slot
	logic [AW:0]   count;       // Words held
	logic          do_push;     // Accepted write
	logic          do_pop;      // Accepted read

	// Honest flags straight from the count
	assign f.in_ready  = (count != (AW+1)'(D));
	assign f.out_valid = (count != '0);
	assign f.out_data  = mem[rd_ptr];
	assign do_push     = f.in_valid && f.in_ready;
	assign do_pop      = f.out_valid && f.out_ready;

	// Storage, written only on accepted push
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= f.in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (!rstn)
		count <= (AW+1)'(D))
		else $error("Buffer holds more words than its depth");
endmodule

// file: verilog/dcs_adc_seq.sv
/*
 * Digital side of a two-input delta-sigma converter: channel sequencing,
 * fourth-order sinc decimation, result word framing and serial readout.
 * Assumes an analog modulator bitstream on mod_bit for the input chosen by
 * ch_sel, scaled so zero-scale sense gives all zeros and full-scale sense
 * all ones; the host drives sck and reads sdo.
 */
`timescale 1ns/10ps
module dcs_adc_seq
	import dcs_pkg::*;
#(
	parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES  // Cycles per modulator sample
) (
	input  wire logic ref_clk,       // Reference clock
	input  wire logic rstn,          // Asynchronous reset, active low
	input  wire logic sck,           // Serial clock from host
	input  wire logic mod_bit,       // Modulator bitstream
	output logic      sdo,           // Serial data out
	output logic      ch_sel,        // Analog input select
	output logic      ext_sck_mode,  // External serial clock mode
	output logic      converting     // Conversion in progress
);

	// Synchronisers
	logic       sck_s1, sck_s2;       // Serial clock level
	logic       mod_s1, mod_s2;       // Modulator bitstream
	logic       done_s1, done_s2, done_s3;   // Frame end toggle
	logic       start_s1, start_s2, start_s3; // Frame start toggle

	// Sequencer
	dcs_state_e state;                // Current state
	logic [1:0] strap_cnt;            // Start-up wait
	logic       start_seen;           // Link activity since sleep
	logic       start_pulse;          // Frame started on the link
	logic       done_pulse;           // Frame finished on the link

	// Sampling and filter
	logic [12:0]        strobe_cnt;   // Sample period counter
	logic               strobe;       // One modulator sample
	logic [SCNT_W-1:0]  samp_cnt;     // Sample within conversion
	logic [ACC_W-1:0]   integ [SINC_ORDER]; // Integrator chain
	logic [ACC_W-1:0]   dly   [SINC_ORDER]; // Comb delays
	logic [ACC_W-1:0]   comb  [SINC_ORDER]; // Comb outputs
	logic               conv_done;    // Final sample taken

	// Result and readout
	logic [WORD_W-1:0]  res_word;     // Word awaiting the buffer
	logic               res_valid;    // Word offered to the buffer
	logic [WORD_W-1:0]  hold_word;    // Word on the link
	logic               hold_valid;   // Link word ready
	logic [4:0]         bit_idx;      // Link bit counter
	logic               done_tgl;     // Link frame end event
	logic               start_tgl;    // Link frame start event

	dcs_fifo_if #(.W(WORD_W)) fq ();

	dcs_fifo #(
		.W (WORD_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk  (ref_clk),
		.rstn (rstn),
		.f    (fq.buf_side)
	);

	// Clip filter output to the code range
	function automatic logic [RES_W-1:0] to_code(input logic [ACC_W-1:0] acc);
		if (acc[ACC_W-1]) begin
			to_code = FULL_CODE;
		end else begin
			to_code = acc[ACC_W-2 -: RES_W];    // Zero input stays zero
		end
	endfunction

	// Bit sent at a given position of the frame
	function automatic logic frame_bit(input logic [WORD_W-1:0] w, input logic [4:0] idx);
		frame_bit = w[LAST_BIT - idx];
	endfunction

	// Pin synchronisers, second flop feeds logic
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			mod_s1 <= 1'b0;
			mod_s2 <= 1'b0;
		end else begin
			sck_s1 <= sck;
			sck_s2 <= sck_s1;
			mod_s1 <= mod_bit;
			mod_s2 <= mod_s1;
		end
	end

	// Link event synchronisers with edge stage
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			done_s1  <= 1'b0;
			done_s2  <= 1'b0;
			done_s3  <= 1'b0;
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_s3 <= 1'b0;
		end else begin
			done_s1  <= done_tgl;
			done_s2  <= done_s1;
			done_s3  <= done_s2;
			start_s1 <= start_tgl;
			start_s2 <= start_s1;
			start_s3 <= start_s2;
		end
	end
	assign done_pulse  = done_s2 ^ done_s3;
	assign start_pulse = start_s2 ^ start_s3;

	// Strap capture once the synchroniser has filled
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			strap_cnt    <= 2'h0;
			ext_sck_mode <= 1'b0;
		end else if (state == ST_STRAP) begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == STRAP_WAIT) begin
				ext_sck_mode <= ~sck_s2;        // Low level picks host clock
			end
		end
	end

	// Modulator sample strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			strobe_cnt <= 13'h0000;
		end else if (state != ST_CONV || strobe) begin
			strobe_cnt <= 13'h0000;             // Restart period per conversion
		end else begin
			strobe_cnt <= strobe_cnt + 13'h0001;
		end
	end
	assign strobe    = (state == ST_CONV) && (strobe_cnt == 13'(SAMPLE_PERIOD - 1));
	assign conv_done = strobe && (samp_cnt == LAST_SAMPLE);

	// Comb chain on the newest integrator value
	always_comb begin
		comb[0] = integ[SINC_ORDER-1] - dly[0];
		for (int k = 1; k < SINC_ORDER; k++) begin
			comb[k] = comb[k-1] - dly[k];
		end
	end

	// Integrators and combs, cleared per conversion so one result settles
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			samp_cnt <= '0;
			for (int k = 0; k < SINC_ORDER; k++) begin
				integ[k] <= '0;
				dly[k]   <= '0;
			end
		end else if (state != ST_CONV) begin
			samp_cnt <= '0;
			for (int k = 0; k < SINC_ORDER; k++) begin
				integ[k] <= '0;
				dly[k]   <= '0;
			end
		end else if (strobe) begin
			samp_cnt <= samp_cnt + SCNT_W'(1);
			integ[0] <= integ[0] + ACC_W'(mod_s2);
			for (int k = 1; k < SINC_ORDER; k++) begin
				integ[k] <= integ[k] + integ[k-1];
			end
			if (samp_cnt[7:0] == DECIM_LAST) begin   // Decimate by 256
				dly[0] <= integ[SINC_ORDER-1];
				for (int k = 1; k < SINC_ORDER; k++) begin
					dly[k] <= comb[k-1];
				end
			end
		end
	end

	// Sequencer: strap, convert, sleep until the host clocks a frame
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state  <= ST_STRAP;
			ch_sel <= 1'b0;                     // First input after power-up
		end else begin
			unique case (state)
				ST_STRAP: begin
					if (strap_cnt == STRAP_WAIT) begin
						state <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (conv_done) begin
						state <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					// Leave only once stored and the link has woken us
					if (!res_valid && start_seen) begin
						state  <= ST_CONV;
						ch_sel <= ~ch_sel;
					end
				end
			endcase
		end
	end
	assign converting = (state == ST_CONV);

	// Sticky wake flag, a new start wins over the clear
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			start_seen <= 1'b0;
		end else if (start_pulse) begin
			start_seen <= 1'b1;
		end else if (state == ST_CONV) begin
			start_seen <= 1'b0;
		end
	end

	// Result framing; held until the buffer has room
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			res_word  <= '0;
			res_valid <= 1'b0;
		end else if (conv_done) begin
			res_word           <= '0;
			res_word[BIT_CH]   <= ch_sel;       // Channel flag
			res_word[BIT_SIGN] <= 1'b1;
			res_word[BIT_EXR]  <= 1'b0;
			res_word[RES_W-1:0] <= to_code(comb[SINC_ORDER-1]);
			res_valid          <= 1'b1;
		end else if (fq.in_ready) begin
			res_valid <= 1'b0;
		end
	end
	assign fq.in_valid = res_valid;
	assign fq.in_data  = res_word;

	// Drain side: load the link word while the link is idle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hold_word  <= '0;
			hold_valid <= 1'b0;
		end else if (fq.out_valid && fq.out_ready) begin
			hold_word  <= fq.out_data;
			hold_valid <= 1'b1;
		end else if (done_pulse) begin
			hold_valid <= 1'b0;
		end
	end
	assign fq.out_ready = !hold_valid;

	// Link side on the host clock; word is static for the whole frame
	always_ff @(negedge sck or negedge rstn) begin
		if (!rstn) begin
			bit_idx   <= 5'h00;
			done_tgl  <= 1'b0;
			start_tgl <= 1'b0;
		end else if (hold_valid) begin
			if (bit_idx == 5'h00) begin
				start_tgl <= ~start_tgl;        // Wakes the converter
			end
			if (bit_idx == LAST_BIT) begin
				bit_idx  <= 5'h00;
				done_tgl <= ~done_tgl;
			end else begin
				bit_idx <= bit_idx + 5'h01;
			end
		end
	end

	// High while no result waits, so the host sees end of conversion
	assign sdo = hold_valid ? frame_bit(hold_word, bit_idx) : 1'b1;

	// Helper counters for checks
	logic [12:0] gap_cnt;      // Cycles since last strobe
	logic        gap_armed;    // A strobe was seen this conversion
	logic [10:0] samp_seen;    // Strobes this conversion
	logic        ones_only;    // Every sample so far was high
	logic        zeros_only;   // Every sample so far was low
	// Flat-stream flags let the code checks fire on real stimulus, not on the filter sum
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gap_cnt    <= 13'h0000;
			gap_armed  <= 1'b0;
			samp_seen  <= 11'h000;
			ones_only  <= 1'b1;
			zeros_only <= 1'b1;
		end else if (state != ST_CONV) begin
			gap_cnt    <= 13'h0000;
			gap_armed  <= 1'b0;
			samp_seen  <= 11'h000;
			ones_only  <= 1'b1;
			zeros_only <= 1'b1;
		end else begin
			gap_cnt    <= strobe ? 13'h0000 : gap_cnt + 13'h0001;
			gap_armed  <= gap_armed | strobe;
			samp_seen  <= samp_seen + 11'(strobe);
			ones_only  <= ones_only & (mod_s2 | !strobe);
			zeros_only <= zeros_only & (!mod_s2 | !strobe);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	first_channel_a: assert property (
		(state == ST_STRAP) ##1 (state == ST_CONV) |-> !ch_sel)
		else $error("First conversion not on first input");
	channel_swap_a: assert property (
		(state == ST_SLEEP) ##1 (state == ST_CONV) |-> ch_sel != $past(ch_sel))
		else $error("Channel did not alternate");
	channel_flag_a: assert property (
		fq.in_valid |-> fq.in_data[BIT_CH] == ch_sel)
		else $error("Channel flag does not match input");
	full_code_a: assert property (
		conv_done && ones_only && mod_s2 |=> res_word[RES_W-1:0] == FULL_CODE)
		else $error("Full-scale input not all ones");
	zero_code_a: assert property (
		conv_done && zeros_only && !mod_s2 |=> res_word[RES_W-1:0] == ZERO_CODE)
		else $error("Zero-scale input not all zeros");
	sample_rate_a: assert property (
		strobe && gap_armed |-> gap_cnt == 13'(SAMPLE_PERIOD - 1))
		else $error("Modulator sample spacing wrong");
	sinc_length_a: assert property (
		conv_done |-> samp_seen == 11'(CONV_SAMPLES - 1) ##1 state == ST_SLEEP)
		else $error("Conversion length not four windows");
	strap_hold_a: assert property (
		state != ST_STRAP |=> $stable(ext_sck_mode))
		else $error("Clock mode changed after start-up");
	sleep_wait_a: assert property (
		state == ST_SLEEP && !start_seen && !start_pulse |=> state != ST_CONV)
		else $error("Converter woke without link activity");

	conv_ch1_c: cover property (conv_done && ch_sel);
	buffer_push_c: cover property (fq.in_valid && fq.in_ready);
	frame_end_c: cover property (done_pulse ##[1:40] state == ST_CONV);
endmodule

// file: verif/dcs_host_model.sv
/*
 * Host side of the two-wire result link: drives the serial clock, reads
 * 24-bit result words from the data-out line MSB first.
 * Assumes the caller waits for data-out low before starting a frame.
 */
`timescale 1ns/10ps
module dcs_host_model (
	output logic      sck,  // Serial clock, idle low between frames
	input  wire logic sdo   // Serial data from the device
);
	localparam realtime HALF = 7.5;  // Half of the 15 ns link period

	// Low idle doubles as the external clock strap at start-up
	initial begin
		sck = 1'b0;
	end

	// Strap or idle level; clock stands still outside frames
	task automatic set_idle(input logic lvl);
		sck = lvl;
	endtask

	// One whole frame of 24 clocks; only clock and data are used
	task automatic read_word(output logic [23:0] w);
		w = 24'h000000;
		#3.3;  // Off the reference grid, so phase stays unrelated
		for (int i = 23; i >= 0; i--) begin
			#HALF;
			sck = 1'b1;
			w[i] = sdo;  // Sampled at the rising edge
			#HALF;
			sck = 1'b0;  // Device moves on at the falling edge
		end
		// Caller attributes the word by count and checks its flag bit against that
	endtask
endmodule

// file: verif/tb_dual_channel_adc_sequencer.sv
/*
 * Self-checking bench of the two-channel converter sequencer: strap, reset,
 * channel alternation, full-scale, zero-scale and mid-scale results.
 * Assumes a 100 MHz reference clock and a shortened sample period of 4.
 */
`timescale 1ns/10ps
module tb_dual_channel_adc_sequencer;
	import dcs_pkg::*;

	localparam int unsigned SP   = 4;         // Cycles per modulator sample
	localparam int unsigned CONV = 1024 * SP; // Cycles per conversion

	logic        ref_clk;       // Reference clock
	logic        rstn;          // Reset, active low
	logic        mod_bit;       // Modulator stream
	logic        sck;           // Link clock from host model
	logic        sdo;           // Link data
	logic        ch_sel;        // Input select
	logic        ext_sck_mode;  // Strap result
	logic        converting;    // Conversion busy
	logic [1:0]  mod_mode;      // 0 zeros, 1 ones, 2 half duty
	logic [2:0]  mod_cnt;       // Half duty pattern counter
	logic [15:0] conv_run;      // Length of current conversion
	logic [15:0] last_run;      // Length of last finished conversion
	int          err_total;     // Mismatches
	int          check_count;   // Comparisons

	dcs_adc_seq #(.SAMPLE_PERIOD(SP)) dut (
		.ref_clk      (ref_clk),
		.rstn         (rstn),
		.sck          (sck),
		.mod_bit      (mod_bit),
		.sdo          (sdo),
		.ch_sel       (ch_sel),
		.ext_sck_mode (ext_sck_mode),
		.converting   (converting)
	);

	dcs_host_model host (
		.sck (sck),
		.sdo (sdo)
	);

	// Reference clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Modulator stream; half duty toggles every 4 cycles so samples alternate
	always @(posedge ref_clk) begin
		mod_cnt <= mod_cnt + 3'h1;
		mod_bit <= (mod_mode == 2'h2) ? mod_cnt[2] : mod_mode[0];
	end

	// Measure how long each conversion lasts
	always @(posedge ref_clk) begin
		if (converting === 1'b1) begin
			conv_run <= conv_run + 16'h0001;
		end else if (conv_run != 16'h0000) begin
			last_run <= conv_run;
			conv_run <= 16'h0000;
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts, verdict, end of run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Reset with a chosen clock strap level
	task automatic do_reset(input logic strap);
		host.set_idle(strap);
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check({sdo, ch_sel, ext_sck_mode, converting}, 32'h8);
		rstn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check(ext_sck_mode, !strap);
		check(ch_sel, 1'b0);
		check(converting, 1'b1);
	endtask

	// Wait for a result, check sleep, read it and check the next start
	task automatic read_check(input logic ch, input logic [19:0] lo,
	                          input logic [19:0] hi, input logic [1:0] next_mode);
		logic [23:0] w;
		int          n;
		n = 0;
		while (sdo !== 1'b0 && n < CONV + 200) begin
			@(posedge ref_clk);
			n++;
		end
		check(n < CONV + 200, 1'b1);
		// Sample count and period set the conversion length
		check(last_run >= CONV && last_run <= CONV + 2, 1'b1);
		check(ch_sel, ch);
		// Device sleeps with the word held until the host clocks
		repeat (50) @(posedge ref_clk);
		check({converting, sdo, ch_sel}, {2'b00, ch});
		mod_mode <= next_mode;
		@(posedge ref_clk);
		host.read_word(w);
		check(w[23:20], {1'b0, ch, 2'b10});
		check(w[19:0] >= lo && w[19:0] <= hi, 1'b1);
		repeat (20) @(posedge ref_clk);
		check({converting, ch_sel}, {1'b1, !ch});
	endtask

	// Strap high then a mid-run reset with strap low
	task automatic test_strap();
		do_reset(1'b1);
		repeat (100) @(posedge ref_clk);
		do_reset(1'b0);
		$display("test strap done");
	endtask

	// First-channel all-ones stream
	task automatic test_full_first();
		read_check(1'b0, FULL_CODE, FULL_CODE, 2'h0);
		$display("test full first done");
	endtask

	// Alternation through zero scale on the second channel and full scale on the first
	task automatic test_alternate();
		read_check(1'b1, ZERO_CODE, ZERO_CODE, 2'h1);
		read_check(1'b0, FULL_CODE, FULL_CODE, 2'h0);
		read_check(1'b1, ZERO_CODE, ZERO_CODE, 2'h2);
		$display("test alternate done");
	endtask

	// Half duty stream lands near mid scale after the filter
	task automatic test_mid_scale();
		read_check(1'b0, 20'h7f800, 20'h80800, 2'h1);
		$display("test mid scale done");
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		mod_bit = 1'b1;
		mod_mode = 2'h1;
		mod_cnt = 3'h0;
		conv_run = 16'h0000;
		last_run = 16'h0000;
		err_total = 0;
		check_count = 0;
		repeat (4) @(posedge ref_clk);
		test_strap();
		test_full_first();
		test_alternate();
		test_mid_scale();
		print_verdict();
	end

	// Watchdog, about five times the expected run
	initial begin
		#1ms;
		err_total++;
		print_verdict();
	end
endmodule
